// [remote_uart.sv]
/* Model of the far side: remote sender, clear pin and transmit timing.
   Assumes one clock shared with the block and eleven-bit characters. */
`timescale 1ns/100ps
module remote_uart #(
  parameter CHAR_CYCLES = 22
) (
  input  wire        clk,
  input  wire        rst_b,
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic [2:0] rx_err,
  output logic       cts_n_pin,
  output logic       tx_char_done
);
  logic [7:0] char_timer;
  initial begin
    rx_valid  = 1'b0;
    rx_data   = 8'h5A;
    rx_err    = 3'h5;
    cts_n_pin = 1'b0;
  end
  // Released data lines show the inverse of the last character
  task automatic send(input logic [7:0] d, input logic [2:0] e);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data  <= d;
    rx_err   <= e;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~d;
    rx_err   <= ~e;
  endtask
  task automatic set_cts(input logic v);
    @(posedge clk);
    cts_n_pin <= v;
  endtask
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      char_timer   <= 8'h00;
      tx_char_done <= 1'b0;
    end else begin
      char_timer   <= (char_timer == CHAR_CYCLES - 1) ? 8'h00 : char_timer + 8'h01;
      tx_char_done <= (char_timer == CHAR_CYCLES - 1);
    end
  end
endmodule

// [rx_fifo.v]
/*
 * Receive FIFO: flip-flop storage, data plus error tags per entry.
 * Assumes one clock; writes beyond full and reads of empty are ignored.
 */
`timescale 1ns/100ps
`include "rx_flow_defines.vh"

module rx_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst_b,
  input  wire             wr,
  input  wire [WIDTH-1:0] wdata,
  input  wire             rd,
  output wire [WIDTH-1:0] rdata,
  output wire [WIDTH-1:0] next_rdata,
  output reg  [AW:0]      count,
  output wire             full,
  output wire             empty
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wptr;
  reg [AW-1:0]    rptr;
  wire            do_wr;
  wire            do_rd;

  assign full  = (count == DEPTH);
  assign empty = (count == {(AW+1){1'b0}});
  assign do_wr = wr && !full;
  assign do_rd = rd && !empty;
  assign rdata = mem[rptr];
  // Entry behind the head, shown at once after a read
  assign next_rdata = mem[rptr + 1'b1];

  // ==========================================================
  // Storage and pointers
  // ==========================================================
  always @(posedge clk) begin
    if (do_wr) begin
      mem[wptr] <= wdata;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr  <= {AW{1'b0}};
      rptr  <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wptr <= wptr + 1'b1;
      end
      if (do_rd) begin
        rptr <= rptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// [rx_flow_defines.vh]
/*
 * Constants for the UART receive holding and flow control block.
 * Assumes it is included by bare name from the design files.
 */
`ifndef RX_FLOW_DEFINES_VH
`define RX_FLOW_DEFINES_VH

// ==========================================================
// Register bit positions
// ==========================================================
`define FCR_FIFO_EN      0
`define EFR_SPECIAL      5
`define EFR_ENH          4
`define EFR_AUTO_RTS     6
`define EFR_AUTO_CTS     7
`define IER_XOFF         5
`define IER_RTS          6
`define IER_CTS          7
`define MCR_RTS          1
`define LSR_TAG_LO       2

// ==========================================================
// Trigger selects and thresholds
// ==========================================================
`define TRIG_1           2'h0
`define TRIG_4           2'h1
`define TRIG_8           2'h2
`define TRIG_14          2'h3
`define LVL_0            5'h00
`define LVL_1            5'h01
`define LVL_4            5'h04
`define LVL_8            5'h08
`define LVL_14           5'h0E

// ==========================================================
// Software flow control modes
// ==========================================================
`define SWF_OFF          2'h0
`define SWF_SINGLE_1     2'h1
`define SWF_SINGLE_2     2'h2
`define SWF_DOUBLE       2'h3

// ==========================================================
// Timing
// ==========================================================
`define CHAR_BITS_MAX    4'hB
`define XOFF_DELAY_CHARS 2'h2

`endif

// [rx_flow_properties.sv]
/* Assertions for the receive holding and flow control block.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/100ps
module rx_flow_properties #(
  parameter DEPTH = 16
) (
  input wire       clk,
  input wire       rst_b,
  input wire       rx_valid,
  input wire [7:0] rx_data,
  input wire       host_rd,
  input wire [1:0] rx_trigger_sel,
  input wire [7:0] enhanced_feature_reg,
  input wire [1:0] sw_flow_mode,
  input wire [7:0] modem_control_reg,
  input wire [7:0] interrupt_enable_reg,
  input wire [7:0] line_control_reg,
  input wire       cts_n_pin,
  input wire [4:0] rx_fifo_count,
  input wire       rts_n,
  input wire       send_pause,
  input wire       pause_flag,
  input wire       special_flag,
  input wire       modem_flag,
  input wire       irq,
  input wire [7:0] pause_char_second
);
  // ==========
  // Request hysteresis levels
  wire [4:0] hi_lvl = (rx_trigger_sel == 2'h0) ? 5'h04 :
                      (rx_trigger_sel == 2'h1) ? 5'h08 : 5'h0E;
  wire [4:0] lo_lvl = (rx_trigger_sel == 2'h0) ? 5'h00 : (rx_trigger_sel == 2'h1) ? 5'h01 :
                      (rx_trigger_sel == 2'h2) ? 5'h04 : 5'h08;
  wire       auto_rts = enhanced_feature_reg[6] & modem_control_reg[1];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  rts_high_a: assert property (
    auto_rts && rx_fifo_count >= hi_lvl |=> rts_n || !auto_rts) else $error("request not raised");
  rts_low_a: assert property (
    auto_rts && rx_fifo_count <= lo_lvl |=> !rts_n || !auto_rts) else $error("request not lowered");
  rts_flag_a: assert property (
    $rose(rts_n) && interrupt_enable_reg[6] && enhanced_feature_reg[4] |-> ##[0:2] modem_flag)
    else $error("request rise not flagged");
  cts_flag_a: assert property (
    $rose(cts_n_pin) && interrupt_enable_reg[7] && enhanced_feature_reg[4]
    && enhanced_feature_reg[7] |-> ##[1:4] modem_flag) else $error("clear rise not flagged");
  pause_irq_a: assert property (
    pause_flag && interrupt_enable_reg[5] |-> irq) else $error("pause flag without interrupt");
  special_char_a: assert property (
    rx_valid && enhanced_feature_reg[5] && sw_flow_mode == 2'h0 && line_control_reg[1:0] == 2'h3
    && rx_data == pause_char_second |-> ##[1:3] special_flag) else $error("special not flagged");
  full_hold_a: assert property (
    rx_fifo_count == DEPTH && !host_rd |=> rx_fifo_count == DEPTH) else $error("full count moved");
  pause_pulse_a: assert property (
    send_pause |=> !send_pause) else $error("pause request too long");
endmodule

// [tb.sv]
/* Testbench for the receive holding and flow control block.
   Assumes the remote model drives the receive stream and clear pin. */
`timescale 1ns/100ps
module tb;
  logic       clk = 1'b0, rst_b = 1'b0, host_rd = 1'b0, char_wr = 1'b0, status_rd = 1'b0;
  logic [1:0] char_sel = 2'h0, rx_trigger_sel = 2'h0, sw_flow_mode = 2'h0;
  logic [7:0] char_wdata = 8'h00, fifo_control_reg = 8'h01, enhanced_feature_reg = 8'h00;
  logic [7:0] modem_control_reg = 8'h00, interrupt_enable_reg = 8'h00, line_control_reg = 8'h03;
  wire        rx_valid, cts_n_pin, tx_char_done, rx_data_ready, rts_n, tx_halt, irq;
  wire        send_pause, send_resume, pause_flag, special_flag, modem_flag;
  wire  [7:0] rx_data, rx_holding_reg, resume_char_first, resume_char_second;
  wire  [7:0] pause_char_first, pause_char_second;
  wire  [2:0] rx_err, line_status_tags;
  wire  [4:0] rx_fifo_count;
  int         mismatches = 0, total_checks = 0, pause_seen = 0, resume_seen = 0;
  logic [4:0] hi_t [4] = '{5'h04, 5'h08, 5'h0E, 5'h0E};
  logic [4:0] lo_t [4] = '{5'h00, 5'h01, 5'h04, 5'h08};
  always #20 clk = ~clk;
  always @(posedge clk) begin
    pause_seen  <= pause_seen + send_pause;
    resume_seen <= resume_seen + send_resume;
  end
  uart_rx_holding_flow_control #(.BIT_CYCLES(2)) u_uart_rx_holding_flow_control (
    .clk, .rst_b, .rx_valid, .rx_data, .rx_err, .host_rd, .fifo_control_reg, .rx_trigger_sel,
    .enhanced_feature_reg, .sw_flow_mode, .modem_control_reg, .interrupt_enable_reg,
    .line_control_reg, .char_wr, .char_sel, .char_wdata, .status_rd, .cts_n_pin,
    .tx_char_done, .rx_holding_reg, .line_status_tags, .rx_data_ready, .rx_fifo_count, .rts_n,
    .tx_halt, .send_pause, .send_resume, .pause_flag, .special_flag, .modem_flag, .irq,
    .resume_char_first, .resume_char_second, .pause_char_first, .pause_char_second);
  remote_uart u_remote_uart (.clk, .rst_b, .rx_valid, .rx_data, .rx_err, .cts_n_pin,
    .tx_char_done);
  // ==========
  // Access tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rd_host;
    @(posedge clk);
    host_rd <= 1'b1;
    @(posedge clk);
    host_rd <= 1'b0;
  endtask
  task automatic stat;
    @(posedge clk);
    status_rd <= 1'b1;
    @(posedge clk);
    status_rd <= 1'b0;
  endtask
  task automatic wchar(input logic [1:0] s, input logic [7:0] v);
    @(posedge clk);
    char_wr    <= 1'b1;
    char_sel   <= s;
    char_wdata <= v;
    @(posedge clk);
    char_wr <= 1'b0;
  endtask
  task automatic drain;
    repeat (17) begin
      if (rx_fifo_count !== 5'h00) begin
        rd_host;
        tick(1);
      end
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results;
  end
  // ==========
  // Tests
  initial begin
    tick(8);
    rst_b <= 1'b1;
    tick(1);
    chk(resume_char_first | resume_char_second | pause_char_first | pause_char_second, 8'h00);
    u_remote_uart.send(8'hA5, 3'h5);
    u_remote_uart.send(8'h3C, 3'h2);
    tick(2);
    chk(rx_holding_reg, 8'hA5);
    chk(8'(line_status_tags), 8'h05);
    rd_host;
    tick(1);
    chk(8'(line_status_tags), 8'h02);
    chk(rx_holding_reg, 8'h3C);
    rd_host;
    tick(1);
    chk(8'(rx_data_ready), 8'h00);
    for (int i = 0; i < 17; i++) u_remote_uart.send(8'(i), 3'h0);
    tick(2);
    chk(8'(rx_fifo_count), 8'h10);
    for (int i = 0; i < 16; i++) begin
      chk(rx_holding_reg, 8'(i));
      rd_host;
      tick(1);
    end
    $display("test fifo done");
    enhanced_feature_reg <= 8'h50;
    interrupt_enable_reg <= 8'h40;
    tick(1);
    modem_control_reg <= 8'h02;
    for (int t = 0; t < 4; t++) begin
      rx_trigger_sel <= 2'(t);
      repeat (hi_t[t] - 1) u_remote_uart.send(8'h20, 3'h0);
      tick(3);
      chk(8'(rts_n), 8'h00);
      u_remote_uart.send(8'h21, 3'h0);
      tick(3);
      chk(8'(rts_n), 8'h01);
      chk(8'(modem_flag), 8'h01);
      stat;
      repeat (hi_t[t] - lo_t[t] - 1) rd_host;
      tick(3);
      chk(8'(rts_n), 8'h01);
      rd_host;
      tick(3);
      chk(8'(rts_n), 8'h00);
      drain;
    end
    enhanced_feature_reg <= 8'h00;
    modem_control_reg    <= 8'h00;
    interrupt_enable_reg <= 8'h20;
    sw_flow_mode         <= 2'h1;
    stat;
    wchar(2'h2, 8'h13);
    wchar(2'h0, 8'h11);
    $display("test request done");
    for (int k = 0; k < 4; k++) begin
      line_control_reg <= (k < 2) ? 8'h03 : 8'h00;
      u_remote_uart.send(((k < 2) ? 8'h10 : 8'hF0) | (k[0] ? 8'h01 : 8'h03), 3'h0);
      tick(30);
      chk(8'(tx_halt), 8'(!k[0]));
      chk(8'(pause_flag), 8'(!k[0]));
      chk(8'(irq), 8'(!k[0]));
      chk(8'(rx_fifo_count), 8'h00);
    end
    chk(pause_char_first, 8'h13);
    line_control_reg <= 8'h03;
    sw_flow_mode     <= 2'h3;
    wchar(2'h3, 8'h93);
    wchar(2'h1, 8'h91);
    for (int k = 0; k < 3; k++) begin
      u_remote_uart.send((k == 2) ? 8'h11 : 8'h13, 3'h0);
      u_remote_uart.send((k == 0) ? 8'h55 : (k == 1) ? 8'h93 : 8'h91, 3'h0);
      tick(30);
      chk(8'(pause_flag), 8'(k == 1));
    end
    drain;
    $display("test software flow done");
    sw_flow_mode         <= 2'h0;
    enhanced_feature_reg <= 8'h20;
    u_remote_uart.send(8'h93, 3'h0);
    tick(3);
    chk(8'(special_flag), 8'h01);
    chk(rx_holding_reg, 8'h93);
    drain;
    enhanced_feature_reg <= 8'h00;
    rx_trigger_sel       <= 2'h0;
    sw_flow_mode         <= 2'h1;
    u_remote_uart.send(8'h42, 3'h0);
    tick(40);
    chk(8'(pause_seen), 8'h00);
    tick(10);
    chk(8'(pause_seen), 8'h01);
    rd_host;
    tick(3);
    chk(8'(resume_seen), 8'h01);
    $display("test special and pause done");
    sw_flow_mode         <= 2'h0;
    enhanced_feature_reg <= 8'h90;
    interrupt_enable_reg <= 8'h80;
    u_remote_uart.set_cts(1'b1);
    tick(6);
    chk(8'(modem_flag), 8'h01);
    tick(24);
    chk(8'(tx_halt), 8'h01);
    u_remote_uart.set_cts(1'b0);
    tick(30);
    chk(8'(tx_halt), 8'h00);
    enhanced_feature_reg <= 8'h00;
    u_remote_uart.set_cts(1'b1);
    tick(30);
    chk(8'(tx_halt), 8'h00);
    $display("test clear to send done");
    fifo_control_reg <= 8'h00;
    u_remote_uart.send(8'h66, 3'h1);
    tick(2);
    chk(rx_holding_reg, 8'h66);
    chk(8'(rx_data_ready), 8'h01);
    rd_host;
    tick(1);
    chk(8'(rx_data_ready), 8'h00);
    $display("test non fifo done");
    results;
  end
endmodule
bind uart_rx_holding_flow_control rx_flow_properties #(.DEPTH(DEPTH)) u_rx_flow_properties (
  .clk, .rst_b, .rx_valid, .rx_data, .host_rd, .rx_trigger_sel, .enhanced_feature_reg,
  .sw_flow_mode, .modem_control_reg, .interrupt_enable_reg, .line_control_reg, .cts_n_pin,
  .rx_fifo_count, .rts_n, .send_pause, .pause_flag, .special_flag, .modem_flag, .irq,
  .pause_char_second);

// [uart_rx_holding_flow_control.v]
/*
 * UART receive holding path with hardware and software flow control.
 * Assumes the receive shift logic delivers one character per rx_valid
 * pulse in the clk domain, and the transmitter honours tx_halt at
 * character boundaries and sends the pause/resume request it is given.
 */
// Operation
// - Sixteen entries, data plus three error tags
// - FIFO mode shows oldest character
// - Read loads next, updates status tags
// - Auto request needs its feature enable
// - Request rising sets interrupt status flag
// - Request high at next level above, at 14 for trigger 14
// - Request low at level below trigger
// - Keep accepting characters until full
// - Auto clear needs its feature enable
// - Clear input high sets interrupt flag
// - Transmitter stops after stop bit
// - Pause characters match halts transmission
// - Pause match sets flag, interrupt
// - Resume characters restart, clear flag
// - Reset zeroes the four character registers
// - Double mode needs two consecutive matches
// - Flow characters never enter the FIFO, except special character
// - Send pause two characters after trigger
// - Send resume at lower level
// - Special character stored and flagged
// - Compare only the selected word length
`timescale 1ns/100ps
`include "rx_flow_defines.vh"

module uart_rx_holding_flow_control #(
  parameter DEPTH      = 16,
  parameter AW         = 4,
  parameter BIT_CYCLES = 16
) (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       rx_valid,
  input  wire [7:0] rx_data,
  input  wire [2:0] rx_err,
  input  wire       host_rd,
  input  wire [7:0] fifo_control_reg,
  input  wire [1:0] rx_trigger_sel,
  input  wire [7:0] enhanced_feature_reg,
  input  wire [1:0] sw_flow_mode,
  input  wire [7:0] modem_control_reg,
  input  wire [7:0] interrupt_enable_reg,
  input  wire [7:0] line_control_reg,
  input  wire       char_wr,
  input  wire [1:0] char_sel,
  input  wire [7:0] char_wdata,
  input  wire       status_rd,
  input  wire       cts_n_pin,
  input  wire       tx_char_done,
  output reg  [7:0] rx_holding_reg,
  output reg  [2:0] line_status_tags,
  output wire       rx_data_ready,
  output wire [4:0] rx_fifo_count,
  output reg        rts_n,
  output reg        tx_halt,
  output reg        send_pause,
  output reg        send_resume,
  output reg        pause_flag,
  output reg        special_flag,
  output reg        modem_flag,
  output wire       irq,
  output reg  [7:0] resume_char_first,
  output reg  [7:0] resume_char_second,
  output reg  [7:0] pause_char_first,
  output reg  [7:0] pause_char_second
);

  // ==========================================================
  // Declarations
  // ==========================================================
  reg        cts_s1;
  reg        cts_s2;
  reg        cts_q;
  reg        rts_q;
  reg        cts_hold;
  reg        pause_half;
  reg        resume_half;
  reg        pause_sent;
  reg        delay_run;
  reg [15:0] delay_cnt;
  reg        pending_xoff;
  reg        nonfifo_valid;
  reg        next_rts_n;
  reg [4:0]  hi_lvl;
  reg [4:0]  lo_lvl;
  reg [4:0]  trig_lvl;
  wire [10:0] fifo_rdata;
  wire [10:0] fifo_next_rdata;
  wire        fifo_empty;
  wire        fifo_full;
  wire        fifo_en;
  wire        enh;
  wire        auto_rts;
  wire        auto_cts;
  wire        special_en;
  wire        m_pf;
  wire        m_ps;
  wire        m_rf;
  wire        m_rs;
  wire        pause_hit;
  wire        resume_hit;
  wire        flow_char;
  wire        fifo_wr;
  wire        fifo_rd;
  wire        cts_rise;
  wire        rts_rise;
  wire [15:0] delay_max;

  localparam integer DELAY_FULL = BIT_CYCLES * `CHAR_BITS_MAX * `XOFF_DELAY_CHARS;

  // ==========================================================
  // Functions
  // ==========================================================
  // Word length mask
  function match;
    input [7:0] a;
    input [7:0] b;
    input [1:0] wl;
    reg   [7:0] m;
    begin
      m = 8'hFF >> (2'h3 - wl);
      match = ((a & m) == (b & m));
    end
  endfunction

  assign fifo_en    = fifo_control_reg[`FCR_FIFO_EN];
  assign enh        = enhanced_feature_reg[`EFR_ENH];
  assign auto_rts   = enhanced_feature_reg[`EFR_AUTO_RTS];
  assign auto_cts   = enhanced_feature_reg[`EFR_AUTO_CTS];
  assign special_en = enhanced_feature_reg[`EFR_SPECIAL];

  assign m_pf = match(rx_data, pause_char_first, line_control_reg[1:0]);
  assign m_ps = match(rx_data, pause_char_second, line_control_reg[1:0]);
  assign m_rf = match(rx_data, resume_char_first, line_control_reg[1:0]);
  assign m_rs = match(rx_data, resume_char_second, line_control_reg[1:0]);

  // ==========================================================
  // Software flow character matching
  // ==========================================================
  // Double mode needs first half seen before second
  assign pause_hit = rx_valid && (
    (sw_flow_mode == `SWF_SINGLE_1 && m_pf) ||
    (sw_flow_mode == `SWF_SINGLE_2 && m_ps) ||
    (sw_flow_mode == `SWF_DOUBLE && pause_half && m_ps));
  assign resume_hit = rx_valid && (
    (sw_flow_mode == `SWF_SINGLE_1 && m_rf) ||
    (sw_flow_mode == `SWF_SINGLE_2 && m_rs) ||
    (sw_flow_mode == `SWF_DOUBLE && resume_half && m_rs));
  assign flow_char = rx_valid && (sw_flow_mode != `SWF_OFF) &&
                     (m_pf || m_ps || m_rf || m_rs) &&
                     !(special_en && m_ps && !pause_hit);
  assign fifo_wr = rx_valid && !flow_char && fifo_en;
  assign fifo_rd = host_rd && fifo_en;

  rx_fifo #(
    .WIDTH (11),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .clk   (clk),
    .rst_b (rst_b),
    .wr    (fifo_wr),
    .wdata ({rx_err, rx_data}),
    .rd    (fifo_rd),
    .rdata (fifo_rdata),
    .next_rdata (fifo_next_rdata),
    .count (rx_fifo_count),
    .full  (fifo_full),
    .empty (fifo_empty)
  );

  // ==========================================================
  // Holding register view
  // ==========================================================
  assign rx_data_ready = fifo_en ? !fifo_empty : nonfifo_valid;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_holding_reg   <= 8'h00;
      line_status_tags <= 3'h0;
      nonfifo_valid    <= 1'b0;
    end else if (fifo_en) begin
      nonfifo_valid <= 1'b0;
      if (fifo_rd && rx_fifo_count > `LVL_1) begin
        rx_holding_reg   <= fifo_next_rdata[7:0];
        line_status_tags <= fifo_next_rdata[10:8];
      end else if (!fifo_empty && !fifo_rd) begin
        rx_holding_reg   <= fifo_rdata[7:0];
        line_status_tags <= fifo_rdata[10:8];
      end else if (fifo_empty && fifo_wr) begin
        rx_holding_reg   <= rx_data;
        line_status_tags <= rx_err;
      end else if (fifo_rd) begin
        line_status_tags <= 3'h0;
      end
    end else begin
      if (rx_valid && !flow_char) begin
        rx_holding_reg   <= rx_data;
        line_status_tags <= rx_err;
        nonfifo_valid    <= 1'b1;
      end else if (host_rd) begin
        nonfifo_valid    <= 1'b0;
        line_status_tags <= 3'h0;
      end
    end
  end

  // ==========================================================
  // Thresholds
  // ==========================================================
  always @* begin
    case (rx_trigger_sel)
      `TRIG_1: begin
        trig_lvl = `LVL_1;
        hi_lvl   = `LVL_4;
        lo_lvl   = `LVL_0;
      end
      `TRIG_4: begin
        trig_lvl = `LVL_4;
        hi_lvl   = `LVL_8;
        lo_lvl   = `LVL_1;
      end
      `TRIG_8: begin
        trig_lvl = `LVL_8;
        hi_lvl   = `LVL_14;
        lo_lvl   = `LVL_4;
      end
      default: begin
        trig_lvl = `LVL_14;
        hi_lvl   = `LVL_14;
        lo_lvl   = `LVL_8;
      end
    endcase
  end

  // ==========================================================
  // Hardware request output
  // ==========================================================
  always @* begin
    next_rts_n = rts_n;
    if (!modem_control_reg[`MCR_RTS]) begin
      next_rts_n = 1'b1;
    end else if (!auto_rts) begin
      next_rts_n = 1'b0;
    end else if (rx_fifo_count >= hi_lvl) begin
      next_rts_n = 1'b1;
    end else if (rx_fifo_count <= lo_lvl) begin
      next_rts_n = 1'b0;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rts_n <= 1'b1;
      rts_q <= 1'b1;
    end else begin
      rts_n <= next_rts_n;
      rts_q <= rts_n;
    end
  end

  // ==========================================================
  // Clear input and transmit gating
  // ==========================================================
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cts_s1 <= 1'b1;
      cts_s2 <= 1'b1;
      cts_q  <= 1'b1;
    end else begin
      cts_s1 <= cts_n_pin;
      cts_s2 <= cts_s1;
      cts_q  <= cts_s2;
    end
  end

  assign cts_rise = cts_s2 && !cts_q;
  assign rts_rise = rts_n && !rts_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cts_hold <= 1'b0;
      tx_halt  <= 1'b0;
    end else begin
      // Stop at character end, restart on low
      if (!auto_cts || !cts_s2) begin
        cts_hold <= 1'b0;
      end else if (tx_char_done) begin
        cts_hold <= 1'b1;
      end
      tx_halt <= cts_hold || pending_xoff;
    end
  end

  // ==========================================================
  // Software flow state and flags
  // ==========================================================
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pause_half   <= 1'b0;
      resume_half  <= 1'b0;
      pending_xoff <= 1'b0;
      pause_flag   <= 1'b0;
      special_flag <= 1'b0;
      modem_flag   <= 1'b0;
    end else begin
      if (rx_valid) begin
        pause_half  <= m_pf && !pause_half;
        resume_half <= m_rf && !resume_half;
      end
      if (resume_hit && pending_xoff) begin
        pending_xoff <= 1'b0;
      end else if (pause_hit) begin
        pending_xoff <= 1'b1;
      end
      if (pause_hit && interrupt_enable_reg[`IER_XOFF]) begin
        pause_flag <= 1'b1;
      end else if (resume_hit) begin
        pause_flag <= 1'b0;
      end
      if (rx_valid && special_en && m_ps) begin
        special_flag <= 1'b1;
      end else if (status_rd) begin
        special_flag <= 1'b0;
      end
      if (enh && ((interrupt_enable_reg[`IER_RTS] && rts_rise) ||
                  (interrupt_enable_reg[`IER_CTS] && cts_rise))) begin
        modem_flag <= 1'b1;
      end else if (status_rd) begin
        modem_flag <= 1'b0;
      end
    end
  end

  assign irq = pause_flag || special_flag || modem_flag;

  // ==========================================================
  // Automatic pause and resume transmission
  // ==========================================================
  assign delay_max = DELAY_FULL[15:0];

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pause_sent  <= 1'b0;
      delay_run   <= 1'b0;
      delay_cnt   <= 16'h0000;
      send_pause  <= 1'b0;
      send_resume <= 1'b0;
    end else begin
      send_pause  <= 1'b0;
      send_resume <= 1'b0;
      if (sw_flow_mode == `SWF_OFF) begin
        pause_sent <= 1'b0;
        delay_run  <= 1'b0;
      end else if (!pause_sent && !delay_run && rx_fifo_count >= trig_lvl) begin
        delay_run <= 1'b1;
        delay_cnt <= 16'h0000;
      end else if (delay_run) begin
        if (delay_cnt == delay_max - 16'h0001) begin
          delay_run  <= 1'b0;
          pause_sent <= 1'b1;
          send_pause <= 1'b1;
        end else begin
          delay_cnt <= delay_cnt + 16'h0001;
        end
      end else if (pause_sent && rx_fifo_count <= lo_lvl) begin
        pause_sent  <= 1'b0;
        send_resume <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Flow character registers
  // ==========================================================
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resume_char_first  <= 8'h00;
      resume_char_second <= 8'h00;
      pause_char_first   <= 8'h00;
      pause_char_second  <= 8'h00;
    end else if (char_wr) begin
      case (char_sel)
        2'h0: begin
          resume_char_first <= char_wdata;
        end
        2'h1: begin
          resume_char_second <= char_wdata;
        end
        2'h2: begin
          pause_char_first <= char_wdata;
        end
        default: begin
          pause_char_second <= char_wdata;
        end
      endcase
    end
  end

endmodule
